// ==== pkg/pwsb_defs.svh ====
`ifndef PWSB_DEFS_SVH
`define PWSB_DEFS_SVH

`define PWSB_MAX_PORTS     8
`define PWSB_ADDR_W        12
// byte addresses
`define PWSB_OFF_OAM       12'h080
`define PWSB_OFF_PEAK      12'h0d4
`define PWSB_OFF_GEVT      12'h0e0
`define PWSB_OFF_VERSION   12'h0e4
`define PWSB_OFF_STICKY0   12'h0e4
`define PWSB_OFF_STAT0     12'h100
// field layout
`define PWSB_OAM_MASK_HI   31
`define PWSB_OAM_MASK_LO   16
`define PWSB_OAM_VAL_HI    15
`define PWSB_OAM_VAL_LO    0
`define PWSB_TXPK_HI       31
`define PWSB_TXPK_LO       25
`define PWSB_RXPK_HI       9
`define PWSB_RXPK_LO       0
`define PWSB_GEVT_W        10
`define PWSB_STICKY_W      8
`define PWSB_ST_STATE_HI   4
`define PWSB_ST_STATE_LO   2
`define PWSB_ST_RTS        1
`define PWSB_ST_BANK       0
`define PWSB_ST_SMART      24
`define PWSB_ST_PLL_HI     23
`define PWSB_ST_PLL_LO     5
// first port's words, used by the checks
`define PWSB_OFF_STICKY1   12'h0e8
`define PWSB_OFF_LIVE_A1   12'h108
`define PWSB_OFF_LIVE_B1   12'h10c
// global event bit positions
`define PWSB_EV_MAC_OVF    9
`define PWSB_EV_IP_VER     8
`define PWSB_EV_FLUSH      7
`define PWSB_EV_TDM_POOL   6
`define PWSB_EV_RX_FULL    5
`define PWSB_EV_LABEL      4
`define PWSB_EV_OAM_QFULL  3
`define PWSB_EV_OAM_BUF    2
`define PWSB_EV_DAT_QFULL  1
`define PWSB_EV_DAT_BUF    0
// per-port sticky bit positions
`define PWSB_SK_PLL_OVF    7
`define PWSB_SK_DELAY      6
`define PWSB_SK_FILTER     3
`define PWSB_SK_VBUF       2
`define PWSB_SK_FREEZE     0
`define PWSB_RESET_WORD    32'h0000_0000

`endif

// ==== pkg/pwsb_pkg.sv ====
`include "pwsb_defs.svh"
package pwsb_pkg;
    // one register bus request
    typedef struct packed {
        logic [`PWSB_ADDR_W-1:0] addr;
        logic [31:0]             wdata;
        logic                    wr;
        logic                    rd;
    } pwsb_bus_req_t;

    // live state supplied by one port's clock recovery machine
    typedef struct packed {
        logic        smart_off;
        logic [18:0] pll_level;
        logic [2:0]  rec_state;
        logic        serial_mode;
        logic        active_slot_bank;
        logic [2:0]  bw_tune;
        logic [24:0] pdv_std;
        logic [3:0]  conv_count;
    } pwsb_port_stat_t;

    // whole state of the bank
    typedef struct packed {
        logic [31:0]                                     oam_ctrl;
        logic [6:0]                                      tx_peak;
        logic [9:0]                                      rx_peak;
        logic [`PWSB_GEVT_W-1:0]                         gevt;
        logic [`PWSB_MAX_PORTS-1:0][`PWSB_STICKY_W-1:0]  sticky;
        logic [`PWSB_MAX_PORTS-1:0]                      rts_meta;
        logic [`PWSB_MAX_PORTS-1:0]                      rts_sync;
        logic [31:0]                                     rdata;
        logic                                            oam_hit;
    } pwsb_state_t;
endpackage : pwsb_pkg

// ==== verilog/pwsb_bank.sv ====
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "pwsb_defs.svh"
module pwsb_bank #(
    parameter int          NPORTS  = 8,
    parameter logic [31:0] VERSION = 32'h5a5a_0001 // arbitrary value
) (
    // clock and reset
    input  wire logic                                   mclk,
    input  wire logic                                   nrst,
    // register port
    input  wire pwsb_pkg::pwsb_bus_req_t                bus,
    output logic [31:0]                                 rdata,
    // classifier
    input  wire logic                                   cw_valid,
    input  wire logic [15:0]                            cw_upper,
    output logic                                        oam_match,
    output logic [15:0]                                 oam_match_mask,
    output logic [15:0]                                 oam_match_value,
    // fifo occupancy in words
    input  wire logic [6:0]                             tx_level,
    input  wire logic [9:0]                             rx_level,
    // global event pulses, bit n sets event bit n
    input  wire logic [`PWSB_GEVT_W-1:0]                glob_evt,
    // per-port event pulses and live state
    input  wire logic [`PWSB_MAX_PORTS-1:0][7:0]        port_evt,
    input  wire pwsb_pkg::pwsb_port_stat_t [`PWSB_MAX_PORTS-1:0] port_stat,
    input  wire logic [`PWSB_MAX_PORTS-1:0]             serial_request_pin
);
    import pwsb_pkg::*;

    pwsb_state_t cur_ff;
    pwsb_state_t nxt_st;

    // address of a sticky word: 0 when not a sticky word, else port number
    function automatic int sticky_port(input logic [`PWSB_ADDR_W-1:0] a);
        int p;
        p = 0;
        if (a[1:0] == 2'b00 && a > `PWSB_OFF_STICKY0 &&
            a <= `PWSB_OFF_STICKY0 + `PWSB_ADDR_W'(4 * NPORTS))
            p = int'((a - `PWSB_OFF_STICKY0) >> 2);
        return p;
    endfunction : sticky_port

    // address of a live word: 0 when not a live word, else port number
    function automatic int stat_port(input logic [`PWSB_ADDR_W-1:0] a);
        int p;
        p = 0;
        if (a[1:0] == 2'b00 && a >= `PWSB_OFF_STAT0 + `PWSB_ADDR_W'(8) &&
            a < `PWSB_OFF_STAT0 + `PWSB_ADDR_W'(8 * (NPORTS + 1)))
            p = int'((a - `PWSB_OFF_STAT0) >> 3);
        return p;
    endfunction : stat_port

    // first live word of a port: reserved bits zero, request pin gated
    function automatic logic [31:0] live_a(input pwsb_port_stat_t s,
                                            input logic rts);
        logic [31:0] w;
        w = `PWSB_RESET_WORD;
        w[`PWSB_ST_SMART] = s.smart_off;
        w[`PWSB_ST_PLL_HI:`PWSB_ST_PLL_LO] = s.pll_level;
        w[`PWSB_ST_STATE_HI:`PWSB_ST_STATE_LO] = s.rec_state;
        w[`PWSB_ST_RTS]  = s.serial_mode & rts;
        w[`PWSB_ST_BANK] = s.active_slot_bank;
        return w;
    endfunction : live_a

    logic [31:0] rd_word;
    int          sp;
    int          tp;

    // next state: register writes, event latching, peaks, read data
    always_comb begin
        nxt_st = cur_ff;
        sp = sticky_port(bus.addr);
        tp = stat_port(bus.addr);
        rd_word = `PWSB_RESET_WORD;

        // pin synchroniser: second stage alone feeds logic
        nxt_st.rts_meta = serial_request_pin;
        nxt_st.rts_sync = cur_ff.rts_meta;

        // classifier compare against masked value
        nxt_st.oam_hit = cw_valid &&
            (((cw_upper ^ cur_ff.oam_ctrl[`PWSB_OAM_VAL_HI:`PWSB_OAM_VAL_LO])
              & cur_ff.oam_ctrl[`PWSB_OAM_MASK_HI:`PWSB_OAM_MASK_LO])
             == 16'h0000);

        if (bus.wr && bus.addr == `PWSB_OFF_OAM) begin
            nxt_st.oam_ctrl = bus.wdata;
        end

        // peak tracking; a read restarts from present occupancy
        if (bus.rd && bus.addr == `PWSB_OFF_PEAK) begin
            nxt_st.tx_peak = tx_level;
            nxt_st.rx_peak = rx_level;
        end else begin
            if (tx_level > cur_ff.tx_peak) begin
                nxt_st.tx_peak = tx_level;
            end
            if (rx_level > cur_ff.rx_peak) begin
                nxt_st.rx_peak = rx_level;
            end
        end

        // global events: write-one clears, a new event wins the same cycle
        if (bus.wr && bus.addr == `PWSB_OFF_GEVT) begin
            nxt_st.gevt = cur_ff.gevt & ~bus.wdata[`PWSB_GEVT_W-1:0];
        end
        // bit map of glob_evt: 9 mac overflow, 8 ip version, 7 flush,
        // 6 tdm pool, 5 rx full, 4 label depth, 3..0 host drops
        nxt_st.gevt = nxt_st.gevt | glob_evt;

        // per-port sticky words
        for (int p = 0; p < `PWSB_MAX_PORTS; p++) begin
            if (p < NPORTS) begin
                if (bus.wr && sp == p + 1) begin
                    nxt_st.sticky[p] = cur_ff.sticky[p] &
                                       ~bus.wdata[`PWSB_STICKY_W-1:0];
                end
                nxt_st.sticky[p] = nxt_st.sticky[p] | port_evt[p];
            end else begin
                nxt_st.sticky[p] = 8'h00;
            end
        end

        // read multiplexer; unmapped addresses read zero
        if (bus.addr == `PWSB_OFF_OAM) begin
            rd_word = cur_ff.oam_ctrl;
        end else if (bus.addr == `PWSB_OFF_PEAK) begin
            rd_word[`PWSB_TXPK_HI:`PWSB_TXPK_LO] = cur_ff.tx_peak;
            rd_word[`PWSB_RXPK_HI:`PWSB_RXPK_LO] = cur_ff.rx_peak;
        end else if (bus.addr == `PWSB_OFF_GEVT) begin
            rd_word[`PWSB_GEVT_W-1:0] = cur_ff.gevt;
        end else if (bus.addr == `PWSB_OFF_VERSION) begin
            rd_word = VERSION;
        end else if (sp != 0) begin
            rd_word[`PWSB_STICKY_W-1:0] = cur_ff.sticky[sp-1];
        end else if (tp != 0) begin
            // live words are sampled straight from the ports, never held
            if (bus.addr[2]) begin
                rd_word = {port_stat[tp-1].bw_tune,
                           port_stat[tp-1].pdv_std,
                           port_stat[tp-1].conv_count};
            end else begin
                rd_word = live_a(port_stat[tp-1],
                                 cur_ff.rts_sync[tp-1]);
            end
        end
        // data stand only in the cycle after the read strobe
        nxt_st.rdata = bus.rd ? rd_word : `PWSB_RESET_WORD;
    end

    // the single state register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // outputs from flip-flops
    assign rdata           = cur_ff.rdata;
    assign oam_match       = cur_ff.oam_hit;
    assign oam_match_mask  = cur_ff.oam_ctrl[`PWSB_OAM_MASK_HI:`PWSB_OAM_MASK_LO];
    assign oam_match_value = cur_ff.oam_ctrl[`PWSB_OAM_VAL_HI:`PWSB_OAM_VAL_LO];

    // event lines by meaning; the checks below read them by name
    logic mac_receive_overflow_flag;
    logic label_stack_depth_flag;
    logic oam_queue_full_flag;
    logic oam_buffer_lack_flag;
    logic data_queue_full_flag;
    logic data_buffer_lack_flag;
    logic virtual_buffer_limit_flag;
    logic active_slot_bank;

    // a line for six of the ten global events and one port event, so a swapped bit shows up by name
    assign mac_receive_overflow_flag = glob_evt[`PWSB_EV_MAC_OVF];
    assign label_stack_depth_flag    = glob_evt[`PWSB_EV_LABEL];
    assign oam_queue_full_flag       = glob_evt[`PWSB_EV_OAM_QFULL];
    assign oam_buffer_lack_flag      = glob_evt[`PWSB_EV_OAM_BUF];
    assign data_queue_full_flag      = glob_evt[`PWSB_EV_DAT_QFULL];
    assign data_buffer_lack_flag     = glob_evt[`PWSB_EV_DAT_BUF];
    assign virtual_buffer_limit_flag = port_evt[0][`PWSB_SK_VBUF];
    assign active_slot_bank          = port_stat[0].active_slot_bank;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence rd_peak_s;
        bus.rd && bus.addr == `PWSB_OFF_PEAK;
    endsequence
    sequence rd_version_s;
        bus.rd && bus.addr == `PWSB_OFF_VERSION;
    endsequence
    sequence wr_oam_s;
        bus.wr && bus.addr == `PWSB_OFF_OAM;
    endsequence
    sequence rd_gevt_s;
        bus.rd && bus.addr == `PWSB_OFF_GEVT;
    endsequence
    sequence rd_sticky1_s;
        bus.rd && bus.addr == `PWSB_OFF_STICKY1;
    endsequence
    sequence rd_live_a1_s;
        bus.rd && bus.addr == `PWSB_OFF_LIVE_A1;
    endsequence
    sequence rd_live_b1_s;
        bus.rd && bus.addr == `PWSB_OFF_LIVE_B1;
    endsequence

    oam_compare_a: assert property (cw_valid |=> oam_match ==
        ((($past(cw_upper) ^ $past(oam_match_value)) &
          $past(oam_match_mask)) == 16'h0000))
        else $error("oam match wrong");
    tx_peak_a: assert property (!bus.rd |=>
        cur_ff.tx_peak >= $past(tx_level))
        else $error("tx peak below level");
    rx_peak_a: assert property (!bus.rd |=>
        cur_ff.rx_peak >= $past(rx_level))
        else $error("rx peak below level");
    peak_clear_a: assert property (rd_peak_s |=>
        cur_ff.tx_peak == $past(tx_level) && cur_ff.rx_peak == $past(rx_level))
        else $error("peak not restarted on read");
    gevt_set_a: assert property (|glob_evt |=>
        (cur_ff.gevt & $past(glob_evt)) == $past(glob_evt))
        else $error("global event lost");
    gevt_clear_a: assert property (bus.wr && bus.addr == `PWSB_OFF_GEVT &&
        glob_evt == '0 |=> (cur_ff.gevt & $past(bus.wdata[9:0])) == '0)
        else $error("global event not cleared");
    gevt_hold_a: assert property (!bus.wr && glob_evt == '0 |=>
        $stable(cur_ff.gevt))
        else $error("global event changed");
    sticky_set_a: assert property (|port_evt[0] |=>
        (cur_ff.sticky[0] & $past(port_evt[0])) == $past(port_evt[0]))
        else $error("sticky event lost");
    version_a: assert property (rd_version_s |=> rdata == VERSION)
        else $error("version word wrong");
    live_state_a: assert property (rd_live_a1_s |=>
        rdata[`PWSB_ST_STATE_HI:`PWSB_ST_STATE_LO] ==
        $past(port_stat[0].rec_state))
        else $error("live state not current");
    rdata_idle_a: assert property (!bus.rd |=> rdata == 32'h0000_0000)
        else $error("read data outside slot");

    // each global event reaches its own bit
    mac_ovf_ev_a: assert property (
        mac_receive_overflow_flag |=> cur_ff.gevt[`PWSB_EV_MAC_OVF])
        else $error("mac overflow event lost");
    ip_ver_ev_a: assert property (
        glob_evt[`PWSB_EV_IP_VER] |=> cur_ff.gevt[`PWSB_EV_IP_VER])
        else $error("ip version event lost");
    flush_ev_a: assert property (
        glob_evt[`PWSB_EV_FLUSH] |=> cur_ff.gevt[`PWSB_EV_FLUSH])
        else $error("flush event lost");
    tdm_pool_ev_a: assert property (
        glob_evt[`PWSB_EV_TDM_POOL] |=> cur_ff.gevt[`PWSB_EV_TDM_POOL])
        else $error("tdm pool event lost");
    rx_full_ev_a: assert property (
        glob_evt[`PWSB_EV_RX_FULL] |=> cur_ff.gevt[`PWSB_EV_RX_FULL])
        else $error("rx full event lost");
    label_ev_a: assert property (
        label_stack_depth_flag |=> cur_ff.gevt[`PWSB_EV_LABEL])
        else $error("label depth event lost");
    oam_qfull_ev_a: assert property (
        oam_queue_full_flag |=> cur_ff.gevt[`PWSB_EV_OAM_QFULL])
        else $error("oam queue event lost");
    oam_buf_ev_a: assert property (
        oam_buffer_lack_flag |=> cur_ff.gevt[`PWSB_EV_OAM_BUF])
        else $error("oam buffer event lost");
    dat_qfull_ev_a: assert property (
        data_queue_full_flag |=> cur_ff.gevt[`PWSB_EV_DAT_QFULL])
        else $error("data queue event lost");
    dat_buf_ev_a: assert property (
        data_buffer_lack_flag |=> cur_ff.gevt[`PWSB_EV_DAT_BUF])
        else $error("data buffer event lost");

    // named recovery events on the first port
    pll_ovf_stk_a: assert property (
        port_evt[0][`PWSB_SK_PLL_OVF] |=> cur_ff.sticky[0][`PWSB_SK_PLL_OVF])
        else $error("pll overflow sticky lost");
    delay_stk_a: assert property (
        port_evt[0][`PWSB_SK_DELAY] |=> cur_ff.sticky[0][`PWSB_SK_DELAY])
        else $error("delay change sticky lost");
    filter_stk_a: assert property (
        port_evt[0][`PWSB_SK_FILTER] |=> cur_ff.sticky[0][`PWSB_SK_FILTER])
        else $error("filter overflow sticky lost");
    vbuf_stk_a: assert property (
        virtual_buffer_limit_flag |=> cur_ff.sticky[0][`PWSB_SK_VBUF])
        else $error("virtual buffer sticky lost");
    freeze_stk_a: assert property (
        port_evt[0][`PWSB_SK_FREEZE] |=> cur_ff.sticky[0][`PWSB_SK_FREEZE])
        else $error("freeze sticky lost");

    // per-port sticky checks; ports past NPORTS are not mapped
    for (genvar g = 0; g < NPORTS; g++) begin : g_port_chk
        sticky_any_a: assert property (
            |port_evt[g] |=> (cur_ff.sticky[g] & $past(port_evt[g])) ==
            $past(port_evt[g]))
            else $error("port sticky event lost");
        sticky_clr_a: assert property (
            bus.wr && bus.addr == 12'(`PWSB_OFF_STICKY1 + 4 * g) &&
            port_evt[g] == '0 |=>
            (cur_ff.sticky[g] & $past(bus.wdata[`PWSB_STICKY_W-1:0])) == '0)
            else $error("port sticky not cleared");
        sticky_keep_a: assert property (
            !(bus.wr && bus.addr == 12'(`PWSB_OFF_STICKY1 + 4 * g)) &&
            port_evt[g] == '0 |=> $stable(cur_ff.sticky[g]))
            else $error("port sticky changed");
    end

    // match register and its outputs
    oam_write_a: assert property (
        wr_oam_s |=> {oam_match_mask, oam_match_value} == $past(bus.wdata))
        else $error("match register not written");
    oam_read_a: assert property (
        bus.rd && bus.addr == `PWSB_OFF_OAM |=>
        rdata == $past({oam_match_mask, oam_match_value}))
        else $error("match register read wrong");

    // peaks: highest level kept unless the register was just read
    peak_read_a: assert property (
        rd_peak_s |=>
        rdata[`PWSB_TXPK_HI:`PWSB_TXPK_LO] == $past(cur_ff.tx_peak) &&
        rdata[`PWSB_RXPK_HI:`PWSB_RXPK_LO] == $past(cur_ff.rx_peak))
        else $error("peak read wrong");
    tx_peak_max_a: assert property (
        !(bus.rd && bus.addr == `PWSB_OFF_PEAK) |=> cur_ff.tx_peak ==
        ($past(tx_level) > $past(cur_ff.tx_peak) ?
         $past(tx_level) : $past(cur_ff.tx_peak)))
        else $error("tx peak not the highest level");
    rx_peak_max_a: assert property (
        !(bus.rd && bus.addr == `PWSB_OFF_PEAK) |=> cur_ff.rx_peak ==
        ($past(rx_level) > $past(cur_ff.rx_peak) ?
         $past(rx_level) : $past(cur_ff.rx_peak)))
        else $error("rx peak not the highest level");

    // latched words read back with reserved bits low
    gevt_read_a: assert property (
        rd_gevt_s |=> rdata[31:`PWSB_GEVT_W] == '0 &&
        rdata[`PWSB_GEVT_W-1:0] == $past(cur_ff.gevt))
        else $error("global event read wrong");
    sticky_read_a: assert property (
        rd_sticky1_s |=> rdata[31:`PWSB_STICKY_W] == '0 &&
        rdata[`PWSB_STICKY_W-1:0] == $past(cur_ff.sticky[0]))
        else $error("sticky read wrong");

    // request pin passes two flops before the live word sees it
    rts_meta_a: assert property (
        cur_ff.rts_meta == $past(serial_request_pin))
        else $error("pin first stage wrong");
    rts_sync_a: assert property (
        cur_ff.rts_sync == $past(cur_ff.rts_meta))
        else $error("pin second stage wrong");

    // live words of the first port
    live_rts_a: assert property (
        rd_live_a1_s |=> rdata[`PWSB_ST_RTS] ==
        ($past(port_stat[0].serial_mode) & $past(cur_ff.rts_sync[0])))
        else $error("live request bit wrong");
    live_bank_a: assert property (
        rd_live_a1_s |=> rdata[`PWSB_ST_BANK] == $past(active_slot_bank))
        else $error("live bank bit wrong");
    live_fields_a: assert property (
        rd_live_a1_s |=> rdata[`PWSB_ST_SMART:`PWSB_ST_PLL_LO] ==
        $past({port_stat[0].smart_off, port_stat[0].pll_level}))
        else $error("live level fields wrong");
    live_resv_a: assert property (
        rd_live_a1_s |=> rdata[31:`PWSB_ST_SMART+1] == '0)
        else $error("live reserved bits set");
    live_b_a: assert property (
        rd_live_b1_s |=> rdata == $past({port_stat[0].bw_tune,
            port_stat[0].pdv_std, port_stat[0].conv_count}))
        else $error("second live word wrong");

    // no register sits on an unaligned address
    misalign_a: assert property (
        bus.rd && bus.addr[1:0] != 2'b00 |=> rdata == '0)
        else $error("unaligned read not zero");
endmodule : pwsb_bank

// ==== dv/test_pwsb_bank.sv ====
`timescale 1ns/1ps
module test_pwsb_bank;
    import pwsb_pkg::*;
    localparam logic [31:0] VER = 32'h0c0d_0e0f; // arbitrary value
    logic                  mclk;
    logic                  nrst;
    pwsb_bus_req_t         bus;
    logic [31:0]           rdata;
    logic                  cw_valid;
    logic [15:0]           cw_upper;
    logic                  oam_match;
    logic [15:0]           mask_o;
    logic [15:0]           value_o;
    logic [6:0]            tx_level;
    logic [9:0]            rx_level;
    logic [9:0]            glob_evt;
    logic [7:0][7:0]       port_evt;
    pwsb_port_stat_t [7:0] port_stat;
    logic [7:0]            pin;
    int                    err_total;
    int                    comparisons;
    // bench model state
    logic [31:0]           d;
    logic [9:0]            m_gevt;
    logic [7:0][7:0]       m_stk;
    logic [6:0]            tx_max;
    logic [9:0]            rx_max;

    pwsb_bank #(.NPORTS(8), .VERSION(VER)) dut (
        .mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata),
        .cw_valid(cw_valid), .cw_upper(cw_upper), .oam_match(oam_match),
        .oam_match_mask(mask_o), .oam_match_value(value_o),
        .tx_level(tx_level), .rx_level(rx_level), .glob_evt(glob_evt),
        .port_evt(port_evt), .port_stat(port_stat),
        .serial_request_pin(pin));

    // free-running clock, 200 mhz
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        @(posedge mclk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge mclk);
        bus.rd   <= 1'b0;
        #1 q = rdata;
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge mclk);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge mclk);
        bus.wr    <= 1'b0;
    endtask : wr

    task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // watchdog: whole run needs about five hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        logic [15:0]     mk, vl, cw;
        logic [63:0]     r;
        logic [7:0]      pv, ev;
        pwsb_port_stat_t ps;
        int              codes[5] = '{0, 2, 3, 4, 5};
        nrst = 1'b0; bus = '0; cw_valid = 1'b0; cw_upper = '0;
        tx_level = '0; rx_level = '0; glob_evt = '0; port_evt = '0;
        port_stat = '0; pin = '0; err_total = 0; comparisons = 0;
        m_gevt = '0; m_stk = '0; tx_max = '0; rx_max = '0;
        void'($urandom(32'h33e12f58));
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        // reset values, unmapped place, read-only version
        rd(12'h080, d); chk("oam reset", 32'h0, d);
        rd(12'h0e0, d); chk("event reset", 32'h0, d);
        for (int p = 0; p < 8; p++) begin
            rd(12'(12'h0e8 + 4 * p), d); chk("sticky reset", 32'h0, d);
        end
        rd(12'h084, d); chk("unmapped", 32'h0, d);
        wr(12'h0e4, ~VER);
        rd(12'h0e4, d); chk("version", VER, d);
        // match mask and value, then classify control words
        for (int i = 0; i < 6; i++) begin
            mk = 16'($urandom); vl = 16'($urandom) & mk;
            wr(12'h080, {mk, vl});
            rd(12'h080, d); chk("oam reg", {mk, vl}, d);
            chk("mask out", {16'h0, mk}, {16'h0, mask_o});
            chk("value out", {16'h0, vl}, {16'h0, value_o});
            for (int j = 0; j < 4; j++) begin
                cw = 16'($urandom);
                if (j[0]) cw = vl | (cw & ~mk);
                @(posedge mclk);
                cw_valid <= 1'b1;
                cw_upper <= cw;
                @(posedge mclk);
                cw_valid <= 1'b0;
                #1 chk("oam hit", {31'h0, ((cw ^ vl) & mk) == 16'h0},
                    {31'h0, oam_match});
            end
        end
        // peaks since last read, restart from present level
        for (int k = 0; k < 3; k++) begin
            repeat (25) begin
                @(posedge mclk);
                r = {$urandom, $urandom};
                tx_level <= r[6:0];
                rx_level <= r[41:32];
                if (r[6:0] > tx_max) tx_max = r[6:0];
                if (r[41:32] > rx_max) rx_max = r[41:32];
            end
            rd(12'h0d4, d);
            chk("peak", {tx_max, 15'h0, rx_max}, d);
            rd(12'h0d4, d);
            chk("peak restart", {tx_level, 15'h0, rx_level}, d);
            tx_max = tx_level; rx_max = rx_level;
        end
        // each global event latches; write-one clears
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk); glob_evt <= 10'(1 << i);
            @(posedge mclk); glob_evt <= '0;
            m_gevt[i] = 1'b1;
            rd(12'h0e0, d); chk("event", {22'h0, m_gevt}, d);
            r[9:0] = 10'($urandom);
            wr(12'h0e0, {22'h0, r[9:0]}); m_gevt &= ~r[9:0];
            rd(12'h0e0, d); chk("event clr", {22'h0, m_gevt}, d);
        end
        // per-port sticky bits
        for (int p = 0; p < 8; p++) begin
            ev = 8'($urandom) | 8'h01;
            @(posedge mclk); port_evt[p] <= ev;
            @(posedge mclk); port_evt[p] <= '0;
            m_stk[p] |= ev;
            rd(12'(12'h0e8 + 4 * p), d);
            chk("sticky", {24'h0, m_stk[p]}, d);
            ev = 8'($urandom);
            wr(12'(12'h0e8 + 4 * p), {24'h0, ev}); m_stk[p] &= ~ev;
            rd(12'(12'h0e8 + 4 * p), d); chk("sticky clr", {24'h0, m_stk[p]}, d);
        end
        // live words follow the present state, writes ignored
        for (int p = 0; p < 8; p++) begin
            for (int j = 0; j < 2; j++) begin
                r = {$urandom, $urandom}; ps = r[56:0];
                ps.rec_state = 3'(codes[(p + j) % 5]);
                pv = 8'($urandom);
                @(posedge mclk);
                port_stat[p] <= ps; pin <= pv;
                wr(12'(12'h108 + 8 * p), 32'($urandom));
                repeat (3) @(posedge mclk);
                rd(12'(12'h108 + 8 * p), d);
                chk("live a", {7'h0, ps.smart_off, ps.pll_level, ps.rec_state,
                    ps.serial_mode & pv[p], ps.active_slot_bank}, d);
                rd(12'(12'h10c + 8 * p), d);
                chk("live b", {ps.bw_tune, ps.pdv_std, ps.conv_count}, d);
            end
        end
        tally_and_finish();
    end
endmodule : test_pwsb_bank
